//--- hdl/lpbk_bist_params.svh
// Constants for the loopback and self-test channel logic
`ifndef LPBK_BIST_PARAMS_SVH
`define LPBK_BIST_PARAMS_SVH
`define K28_5 8'hbc
`define K27_7 8'hfb
`define K28_0 8'h1c
`define K28_1 8'h3c
`define K28_2 8'h5c
`define K28_3 8'h7c
`define K28_4 8'h9c
`define K28_6 8'hdc
`define K28_7 8'hfc
`define K23_7 8'hf7
`define K30_7 8'hfe
`define K29_7 8'hfd
`define INC_SEQ_LEN 9'h10c
`define PRBS_COUNT 10'h3ff
`define PRBS_SEED 10'h3ff
`define PRBS_ALIGN 10'h3ff
`define PRBS_TAP_A 9
`define PRBS_TAP_B 6
`endif

//--- hdl/lpbk_bist_pkg.sv
// Types shared by the loopback and self-test channel logic
`default_nettype none
package lpbk_bist_pkg;
	typedef enum logic [1:0] {
		TEST_OFF = 2'h0,
		TEST_INC = 2'h1,
		TEST_PRBS = 2'h2
	} test_mode_t;
	typedef enum logic [2:0] {
		LB_NONE = 3'h1,
		LB_SERIAL = 3'h2,
		LB_REV = 3'h4
	} lb_state_t;
	typedef struct packed {
		logic is_k;
		logic [7:0] data;
	} char_t;
	typedef struct packed {
		logic done;
		logic err;
	} bist_flags_t;
endpackage
`default_nettype wire

//--- hdl/pattern_gen.sv
// Incremental character and PRBS10 pattern generator
`include "lpbk_bist_params.svh"
`default_nettype none
module pattern_gen
	import lpbk_bist_pkg::*;
#(
	parameter test_mode_t MODE = TEST_INC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic restart,
	// Pattern out
	output char_t chr_q,
	output logic [9:0] raw_q
);
	logic [8:0] idx_q;
	logic [8:0] idx_d;
	logic [9:0] lfsr_d;
	char_t chr_d;

	// Sequence character at a given step
	function automatic char_t inc_char(input logic [8:0] i);
		char_t c;
		c = '{is_k: 1'b1, data: `K28_5};
		if (i == 9'h000)
			c.data = `K28_5;
		else if (i == 9'h001)
			c.data = `K27_7;
		else if (i < 9'h102)
			c = '{is_k: 1'b0, data: 8'(i - 9'h002)};
		else begin
			case (i)
				9'h102: c.data = `K28_0;
				9'h103: c.data = `K28_1;
				9'h104: c.data = `K28_2;
				9'h105: c.data = `K28_3;
				9'h106: c.data = `K28_4;
				9'h107: c.data = `K28_6;
				9'h108: c.data = `K28_7;
				9'h109: c.data = `K23_7;
				9'h10a: c.data = `K30_7;
				default: c.data = `K29_7;
			endcase
		end
		return c;
	endfunction

	// Wrap after the end-of-frame character
	assign idx_d = (idx_q == `INC_SEQ_LEN - 9'h001) ? 9'h000 : idx_q + 9'h001;
	assign chr_d = inc_char(idx_q);
	// x^10 + x^7 + 1, maximal length
	assign lfsr_d = {raw_q[8:0], raw_q[`PRBS_TAP_A] ^ raw_q[`PRBS_TAP_B]};

	// Step generators
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q <= 9'h000;
			chr_q <= '0;
			raw_q <= `PRBS_SEED;
		end else if (restart) begin
			idx_q <= 9'h000;
			raw_q <= `PRBS_SEED;
		end else begin
			idx_q <= idx_d;
			chr_q <= chr_d;
			raw_q <= (MODE == TEST_PRBS) ? lfsr_d : raw_q;
		end
	end
endmodule
`default_nettype wire

//--- hdl/loopback_bist.sv
// Loopback paths and self-test verifier of one transceiver channel
`include "lpbk_bist_params.svh"
`default_nettype none
module loopback_bist
	import lpbk_bist_pkg::*;
#(
	parameter bit PIPE_MODE = 1'b0,
	parameter bit REV_SERIAL = 1'b0,
	parameter bit ENC_8B10B = 1'b1,
	parameter logic [9:0] ALIGN_PATTERN = 10'h17c,
	parameter test_mode_t TEST_MODE = TEST_INC,
	parameter bit PRBS_SERIAL_LB = 1'b1,
	parameter int SERDES_WIDTH = 10
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic rx_digital_reset,
	// Loopback controls
	input wire logic serial_lpbk_en,
	input wire logic pipe_rev_lpbk,
	// Fabric transmit side
	input wire char_t tx_char,
	// Receive serial and recovered-clock retimed input
	input wire logic rx_serial,
	input wire logic word_sync,
	input wire logic [9:0] rx_raw,
	input wire char_t rx_char,
	input wire logic [9:0] rm_raw,
	// Outputs
	output logic tx_serial,
	output logic tx_drv_en,
	output logic [9:0] tx_raw_q,
	output char_t tx_enc_q,
	output logic enc_bypass_q,
	output logic deskew_en_q,
	output logic rx_from_tx_q,
	output logic [9:0] fabric_raw_q,
	output char_t fabric_char_q,
	output bist_flags_t flags_q
);
	lb_state_t lb_q;
	lb_state_t lb_d;
	char_t gen_chr;
	logic [9:0] gen_raw;
	logic [8:0] vidx_q;
	logic [9:0] vcnt_q;
	logic [9:0] vlfsr_q;
	logic vseed_q;
	logic inc_ok;
	logic prbs_on;
	logic rev_ok;
	logic prbs_ok;
	logic serial_allowed;
	logic [9:0] exp_lfsr;
	bist_flags_t flags_d;
	char_t exp_chr;

	// Expected incremental character, same table as the generator
	function automatic char_t exp_at(input logic [8:0] i);
		char_t c;
		c = '{is_k: 1'b1, data: `K28_5};
		if (i == 9'h001)
			c.data = `K27_7;
		else if (i >= 9'h002 && i < 9'h102)
			c = '{is_k: 1'b0, data: 8'(i - 9'h002)};
		else if (i >= 9'h102) begin
			case (i)
				9'h102: c.data = `K28_0;
				9'h103: c.data = `K28_1;
				9'h104: c.data = `K28_2;
				9'h105: c.data = `K28_3;
				9'h106: c.data = `K28_4;
				9'h107: c.data = `K28_6;
				9'h108: c.data = `K28_7;
				9'h109: c.data = `K23_7;
				9'h10a: c.data = `K30_7;
				default: c.data = `K29_7;
			endcase
		end
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Generator

	// Generator is restarted by the same digital reset as the verifier
	pattern_gen #(
		.MODE(TEST_MODE)
	) u_gen (
		.clk(clk),
		.reset_n(reset_n),
		.restart(rx_digital_reset),
		.chr_q(gen_chr),
		.raw_q(gen_raw)
	);

	////////////////////////////////////////////////////////////////////////
	// Static configuration checks

	// Illegal static combinations simply fall back to no test path
	assign rev_ok = REV_SERIAL && !PIPE_MODE && ENC_8B10B
		&& ALIGN_PATTERN == 10'h17c;
	assign prbs_ok = TEST_MODE == TEST_PRBS && SERDES_WIDTH == 10
		&& ALIGN_PATTERN == `PRBS_ALIGN;
	assign prbs_on = prbs_ok;
	assign inc_ok = TEST_MODE == TEST_INC && ENC_8B10B;
	// Run-time serial loopback only outside PIPE and PRBS-without-loopback
	assign serial_allowed = !PIPE_MODE && !rev_ok
		&& !(TEST_MODE == TEST_PRBS && !PRBS_SERIAL_LB);

	////////////////////////////////////////////////////////////////////////
	// Loopback selection

	// Reverse serial is static; serial loopback follows its input
	always_comb begin
		case (1'b1)
			rev_ok: lb_d = LB_REV;
			serial_allowed && serial_lpbk_en: lb_d = LB_SERIAL;
			default: lb_d = LB_NONE;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			lb_q <= LB_NONE;
		else
			lb_q <= lb_d;
	end

	// Serial output: reverse serial sends the retimed input straight out
	assign tx_serial = (lb_q == LB_REV) ? rx_serial : tx_raw_q[0];
	// Transmit driver stays on in every loopback mode
	assign tx_drv_en = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Transmit datapath and PIPE reverse parallel loopback

	// Rate-matched receive word replaces fabric data when looped back
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_raw_q <= '0;
			tx_enc_q <= '0;
			enc_bypass_q <= 1'b0;
			deskew_en_q <= 1'b0;
			rx_from_tx_q <= 1'b0;
		end else begin
			if (PIPE_MODE && pipe_rev_lpbk)
				tx_raw_q <= rm_raw;
			else if (prbs_on)
				tx_raw_q <= gen_raw;
			else
				tx_raw_q <= tx_raw_q;
			tx_enc_q <= inc_ok ? gen_chr : tx_char;
			enc_bypass_q <= prbs_on;
			deskew_en_q <= PIPE_MODE && !pipe_rev_lpbk;
			rx_from_tx_q <= lb_d == LB_SERIAL;
		end
	end

	// Receive data always reaches the fabric, looped or not
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fabric_raw_q <= '0;
			fabric_char_q <= '0;
		end else begin
			fabric_raw_q <= rx_raw;
			fabric_char_q <= rx_char;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Verifier

	assign exp_chr = exp_at(vidx_q);
	// Verifier LFSR reloads from every synced word before done
	assign exp_lfsr = {vlfsr_q[8:0],
		vlfsr_q[`PRBS_TAP_A] ^ vlfsr_q[`PRBS_TAP_B]};

	// Error is a level that follows mismatch until done
	always_comb begin
		flags_d = flags_q;
		if (flags_q.done)
			flags_d.err = 1'b0;
		else if (inc_ok)
			flags_d.err = rx_char != exp_chr;
		else if (prbs_on && word_sync && vseed_q)
			flags_d.err = rx_raw != exp_lfsr;
		else
			flags_d.err = 1'b0;
		if (inc_ok && vidx_q == `INC_SEQ_LEN - 9'h001)
			flags_d.done = 1'b1;
		if (prbs_on && word_sync && vseed_q
			&& vcnt_q == `PRBS_COUNT - 10'h001)
			flags_d.done = 1'b1;
	end

	// Reverse serial loopback does not need the K28.5 pattern checked here;
	// restart takes priority so a reset pulse always clears done
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flags_q <= '0;
			vidx_q <= '0;
			vcnt_q <= '0;
			vlfsr_q <= '0;
			vseed_q <= 1'b0;
		end else if (rx_digital_reset) begin
			flags_q <= '0;
			vidx_q <= '0;
			vcnt_q <= '0;
			vseed_q <= 1'b0;
		end else if (!flags_q.done) begin
			flags_q <= flags_d;
			if (inc_ok)
				vidx_q <= vidx_q + 9'h001;
			if (prbs_on && word_sync) begin
				vseed_q <= 1'b1;
				vlfsr_q <= rx_raw;
				if (vseed_q)
					vcnt_q <= vcnt_q + 10'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_done_sticky: assert property (@(posedge clk) disable iff (!reset_n)
		flags_q.done && !rx_digital_reset |=> flags_q.done)
		else $error("done dropped without restart");
	a_restart_clear: assert property (@(posedge clk) disable iff (!reset_n)
		rx_digital_reset |=> !flags_q.done && !flags_q.err)
		else $error("restart left flags set");
	a_err_after_done: assert property (@(posedge clk) disable iff (!reset_n)
		flags_q.done |-> !flags_q.err)
		else $error("error raised after done");
	a_inc_err: assert property (@(posedge clk) disable iff (!reset_n)
		inc_ok && !flags_q.done && !rx_digital_reset
		&& rx_char != exp_chr |=> flags_q.err)
		else $error("mismatch not flagged");
	a_deskew_off: assert property (@(posedge clk) disable iff (!reset_n)
		PIPE_MODE && pipe_rev_lpbk |=> !deskew_en_q)
		else $error("deskew on in reverse loopback");
	a_pipe_loop: assert property (@(posedge clk) disable iff (!reset_n)
		PIPE_MODE && pipe_rev_lpbk |=> tx_raw_q == $past(rm_raw))
		else $error("reverse parallel data not looped");
	a_pipe_no_serial: assert property (@(posedge clk) disable iff (!reset_n)
		PIPE_MODE |-> !rx_from_tx_q && lb_q != LB_REV)
		else $error("serial loopback in PIPE");
	a_rev_out: assert property (@(posedge clk) disable iff (!reset_n)
		lb_q == LB_REV |-> tx_serial == rx_serial)
		else $error("reverse serial not passed");
	a_serial_follow: assert property (@(posedge clk) disable iff (!reset_n)
		serial_allowed && serial_lpbk_en |=> rx_from_tx_q)
		else $error("serial loopback not applied");
	a_bypass: assert property (@(posedge clk) disable iff (!reset_n)
		prbs_on |=> enc_bypass_q)
		else $error("encoder not bypassed in PRBS");
endmodule
`default_nettype wire

//--- verif/link_partner.sv
// Far-end model that feeds incremental characters and PRBS10 words
`include "lpbk_bist_params.svh"
`default_nettype none
module link_partner
	import lpbk_bist_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Stream control
	input wire logic restart,
	input wire logic sync,
	input wire logic flip,
	// Streams toward the receiver
	output char_t rx_char,
	output logic [9:0] rx_raw
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] idx_q;
	logic [9:0] lfsr_q;
	char_t c;
	//////////////////////////////////////////////////////////////////////
	// Character at a sequence index, also used by the bench as reference
	function automatic char_t seq(input logic [8:0] i);
		logic [7:0] k [12];
		k = '{`K28_5, `K27_7, `K28_0, `K28_1, `K28_2, `K28_3,
			`K28_4, `K28_6, `K28_7, `K23_7, `K30_7, `K29_7};
		if (i < 9'h2)
			return {1'b1, k[i]};
		if (i < 9'h102)
			return {1'b0, 8'(i - 9'h2)};
		return {1'b1, k[i - 9'h100]};
	endfunction
	// One LFSR step per word, x^10 + x^7 + 1, as the verifier expects
	function automatic logic [9:0] nxt(input logic [9:0] w);
		return {w[8:0], w[`PRBS_TAP_A] ^ w[`PRBS_TAP_B]};
	endfunction
	//////////////////////////////////////////////////////////////////////
	// Unsynced, keep sending the all-ones pattern so the aligner can lock
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_q <= 9'h0;
			lfsr_q <= `PRBS_ALIGN;
		end else begin
			idx_q <= (restart || idx_q == `INC_SEQ_LEN - 9'h1) ? 9'h0 :
				idx_q + 9'h1;
			lfsr_q <= sync ? nxt(lfsr_q) : `PRBS_ALIGN;
		end
	end
	// Flip corrupts one bit of both streams on command only
	assign c = seq(idx_q);
	assign rx_char = {c.is_k, c.data ^ {7'h0, flip}};
	assign rx_raw = lfsr_q ^ {9'h0, flip};
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the loopback and self-test channel
`include "lpbk_bist_params.svh"
`default_nettype none
module testbench
	import lpbk_bist_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, rx_digital_reset, serial_lpbk_en, pipe_rev_lpbk;
	logic rx_serial, word_sync, flip, rp, sl_p, pr_p;
	char_t tx_char, rx_char, rc_p;
	logic [9:0] rx_raw, rm_raw, rm_p, rr_p;
	int n_errors = 0;
	int comparisons = 0;
	//////////////////////////////////////////////////////////////////////
	// Incremental channel, then a PRBS channel on the same inputs
	loopback_bist DUT (.clk, .reset_n, .rx_digital_reset, .serial_lpbk_en,
		.pipe_rev_lpbk, .tx_char, .rx_serial, .word_sync, .rx_raw,
		.rx_char, .rm_raw, .tx_serial(), .tx_drv_en(), .tx_raw_q(),
		.tx_enc_q(), .enc_bypass_q(), .deskew_en_q(), .rx_from_tx_q(),
		.fabric_raw_q(), .fabric_char_q(), .flags_q());
	// PRBS checking needs the all-ones aligner pattern to be enabled
	loopback_bist #(.TEST_MODE(TEST_PRBS), .ALIGN_PATTERN(`PRBS_ALIGN))
		prbs_dut (.clk, .reset_n,
		.rx_digital_reset, .serial_lpbk_en, .pipe_rev_lpbk, .tx_char,
		.rx_serial, .word_sync, .rx_raw, .rx_char, .rm_raw, .tx_serial(),
		.tx_drv_en(), .tx_raw_q(), .tx_enc_q(), .enc_bypass_q(),
		.deskew_en_q(), .rx_from_tx_q(), .fabric_raw_q(),
		.fabric_char_q(), .flags_q());
	// PIPE channel, where only reverse parallel loopback may be used
	loopback_bist #(.PIPE_MODE(1'b1)) pipe_dut (.clk, .reset_n,
		.rx_digital_reset, .serial_lpbk_en, .pipe_rev_lpbk, .tx_char,
		.rx_serial, .word_sync, .rx_raw, .rx_char, .rm_raw, .tx_serial(),
		.tx_drv_en(), .tx_raw_q(), .tx_enc_q(), .enc_bypass_q(),
		.deskew_en_q(), .rx_from_tx_q(), .fabric_raw_q(),
		.fabric_char_q(), .flags_q());
	link_partner lp (.clk, .reset_n, .restart(rx_digital_reset),
		.sync(word_sync), .flip, .rx_char, .rx_raw);
	//////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Restart pulse; the edge that samples it clears both verifiers
	task automatic restart();
		@(posedge clk) rx_digital_reset <= 1'b1;
		@(posedge clk) rx_digital_reset <= 1'b0;
		#1 chk(DUT.flags_q, 2'h0);
		chk(prbs_dut.flags_q, 2'h0);
	endtask
	// One incremental pass with k bad characters from index a
	task automatic inc_pass(input int a, input int k);
		int n, e;
		n = 0;
		e = 0;
		restart();
		while (DUT.flags_q.done !== 1'b1 && n < 400) begin
			flip <= (n >= a && n < a + k);
			@(posedge clk);
			#1 n++;
			e += (DUT.flags_q.err === 1'b1);
		end
		flip <= 1'b0;
		chk(16'(n), `INC_SEQ_LEN);
		chk(16'(e), 16'(k));
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Random traffic on every free input, each rising edge
	always @(posedge clk) begin
		tx_char <= char_t'($urandom);
		rx_serial <= 1'($urandom);
		rm_raw <= 10'($urandom);
		pipe_rev_lpbk <= 1'($urandom);
		serial_lpbk_en <= 1'($urandom);
	end
	// Per-cycle checks against inputs seen one edge earlier
	always @(negedge clk) begin
		if (rp && reset_n) begin
			chk(DUT.rx_from_tx_q, sl_p);
			chk(prbs_dut.rx_from_tx_q, sl_p);
			chk(DUT.fabric_char_q, rc_p);
			chk(DUT.tx_drv_en, 1'b1);
			chk(DUT.tx_serial, DUT.tx_raw_q[0]);
			chk(DUT.deskew_en_q, 1'b0);
			chk(DUT.enc_bypass_q, 1'b0);
			chk(prbs_dut.enc_bypass_q, 1'b1);
			chk(pipe_dut.deskew_en_q, !pr_p);
			chk(pipe_dut.rx_from_tx_q, 1'b0);
			chk(pipe_dut.fabric_raw_q, rr_p);
			if (pr_p)
				chk(pipe_dut.tx_raw_q, rm_p);
		end
		rp = reset_n;
		pr_p = pipe_rev_lpbk;
		rm_p = rm_raw;
		rr_p = rx_raw;
		sl_p = serial_lpbk_en;
		rc_p = rx_char;
	end
	// The whole run needs about 2400 cycles; allow over four times that
	initial begin
		#100000;
		n_errors++;
		print_verdict();
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		int n, e;
		bit seen [1024];
		void'($urandom(45123));
		{reset_n, rx_digital_reset, word_sync, flip, rp} = '0;
		{serial_lpbk_en, pipe_rev_lpbk, rx_serial} = '0;
		tx_char = '0;
		rm_raw = '0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		inc_pass(0, 0);
		inc_pass(0, 1);
		inc_pass(266, 1);
		inc_pass($urandom_range(1, 200), $urandom_range(2, 50));
		// Generator order, starting from its comma
		n = 0;
		while (DUT.tx_enc_q !== {1'b1, `K28_5} && n < 300) begin
			@(posedge clk);
			#1 n++;
		end
		for (int j = 1; j < 268; j++) begin
			@(posedge clk);
			#1 chk(DUT.tx_enc_q, lp.seq(9'(j)));
		end
		// Unsynced corrupted words must not have been judged
		chk(prbs_dut.flags_q, 2'h0);
		restart();
		@(posedge clk) word_sync <= 1'b1;
		n = 0;
		e = 0;
		while (prbs_dut.flags_q.done !== 1'b1 && n < 1100) begin
			@(posedge clk);
			#1 n++;
			e += (prbs_dut.flags_q.err === 1'b1);
			if (n <= 1023) begin
				chk(seen[prbs_dut.tx_raw_q], 1'b0);
				seen[prbs_dut.tx_raw_q] = 1'b1;
			end
		end
		chk(n >= 1024 && n <= 1025, 1'b1);
		chk(16'(e), 16'h0);
		// Second pass with one corrupted word in mid-run
		restart();
		repeat (20) @(posedge clk);
		#1 chk(prbs_dut.flags_q, 2'h0);
		@(posedge clk) flip <= 1'b1;
		@(posedge clk) flip <= 1'b0;
		#1 chk(prbs_dut.flags_q.err, 1'b1);
		print_verdict();
	end
endmodule
`default_nettype wire
